/* File: design/prf_params.svh */
`ifndef PRF_PARAMS_SVH
`define PRF_PARAMS_SVH

// Register offsets on the plain register port
`define PRF_RA_CBADDR  8'h00
`define PRF_RA_CFG     8'h04
`define PRF_RA_STAT    8'h08
`define PRF_RA_HEAD    8'h0C
`define PRF_RA_TAIL    8'h10

// Control block byte offsets; fetch walks words 0..3 then intervals
`define PRF_CB_BASE    32'h0000_0000
`define PRF_CB_SIZE    32'h0000_0004
`define PRF_CB_THR     32'h0000_0008
`define PRF_CB_TAIL    32'h0000_000C
`define PRF_CB_IVL     32'h0000_0010
`define PRF_CB_HEAD    32'h0000_0040
`define PRF_CB_MISS    32'h0000_0044
`define PRF_FETCH_IVL  4'h4

// Record and field constants
`define PRF_REC_BYTES  32'h0000_0004
`define PRF_XBIT       62
`define PRF_RING_USER  2'h3
`define PRF_CFG_VEC_LO 0
`define PRF_CFG_EN_LO  8
`define PRF_CFG_RST    32'h0000_0000

`endif

/* File: design/prf_pkg.sv */
package prf_pkg;
    // Sequencer states, Gray coded in declaration order
    typedef enum logic [2:0] {
        PRF_IDLE  = 3'h0,
        PRF_FETCH = 3'h1,
        PRF_REC   = 3'h3,
        PRF_TAIL  = 3'h2,
        PRF_HEAD  = 3'h6,
        PRF_MISSR = 3'h7,
        PRF_MISSW = 3'h5
    } prf_state_e;
endpackage

/* File: design/prf_mem.sv */
`timescale 1ns/1ns
// Small interval store with registered read data
module prf_mem #(
    parameter int W = 16,
    parameter int D = 6,
    parameter int AW = 3
) (
    // Clock
    input  wire logic          core_clk,
    input  wire logic          ce,
    // Write side
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [W-1:0]  wr_data,
    // Read side
    input  wire logic [AW-1:0] rd_addr,
    output logic      [W-1:0]  rd_data
);
    logic [W-1:0] mem [D];

    // Array write
    always_ff @(posedge core_clk) begin
        if (ce && wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered read
    always_ff @(posedge core_clk) begin
        if (ce) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

/* File: design/prf_core.sv */
// Functional notes
// - Restore with feature and mask set but presence clear zeroes counters, pointers, base, size and threshold, disables profiling; cfg and intervals are kept.
// - Applicable events are counted except while the counter is zero or being reloaded; lowest pending counter is recorded first.
// - Counters, write pointer and tail copy live in internal registers.
// - Restore reloads volatile state; control block fetch waits for ring 3.
// - No lazy scheme; task-switched flag has no effect on profiling.
// - No control block access in kernel, hypervisor or system management.
// - Write pointer flushed on threshold or store-control-block read; a full ring does not flush it.
// - Passing the threshold writes the write pointer to memory only if the reread tail still shows it passed.
// - On threshold or full, reread tail, recompute, act on new result.
// - Tail reread on every record store while threshold appears true.
// - Tail reread every time the ring appears full.
// - Reload intervals cached at control block load.
// - Ring base and size cached internally.
// - Missed-event count lives in memory and is incremented there.
// - Cache refreshed at first idle ring 3 cycle outside hypervisor and system management after load instruction or restore.
// - Threshold interrupt uses configured vector, own output.
// - Absent page during record store raises a page fault.
// - On page fault the record is dropped; next event is reported.
// - Restore never raises the threshold interrupt itself.
`timescale 1ns/1ns
`include "prf_params.svh"
module prf_core
    import prf_pkg::*;
#(
    parameter int NEV = 6,
    parameter int CW  = 16
) (
    // Clock, reset, enable
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Retiring instruction events
    input  wire logic        ev_valid,
    input  wire logic [NEV-1:0] ev_hit,
    input  wire logic [31:0] ev_ip,
    // Execution context
    input  wire logic [1:0]  cpl,
    input  wire logic        smm_active,
    input  wire logic        hyp_active,
    // Extended state restore
    input  wire logic        xr_go,
    input  wire logic [63:0] xr_feature_en,
    input  wire logic [63:0] xr_req_mask,
    input  wire logic [63:0] xr_presence,
    input  wire logic [31:0] xr_cb_addr,
    input  wire logic [31:0] xr_head,
    // User memory port
    output logic             mem_req,
    output logic             mem_we,
    output logic      [31:0] mem_addr,
    output logic      [31:0] mem_wdata,
    input  wire logic        mem_ack,
    input  wire logic        mem_fault,
    input  wire logic [31:0] mem_rdata,
    // Exceptions and interrupt
    output logic             pf_evt,
    output logic             thr_irq,
    output logic      [7:0]  thr_vector,
    output logic             prof_enabled
);
    localparam int IW = $clog2(NEV);
    localparam logic [3:0] FETCH_LAST = 4'(`PRF_FETCH_IVL + NEV - 1);

    prf_state_e  state;
    logic [31:0] cb_addr;
    logic [31:0] cfg;
    logic [31:0] buf_base;
    logic [31:0] buf_size;
    logic [31:0] thr;
    logic [31:0] head;
    logic [31:0] tail;
    logic        refresh_pend;
    logic        flush_req;
    logic        post_rec;
    logic        irq_arm;
    logic [3:0]  idx;
    logic [IW-1:0] svc;
    logic        reload_p;
    logic [NEV-1:0] pend;
    logic [NEV-1:0] pend_clr;
    logic [CW-1:0]  cnt [NEV];
    logic [CW-1:0]  ivl_rd;
    logic        access_ok;
    logic        count_ok;
    logic        xr_clear;
    logic        xr_load;
    logic        cb_wr;
    logic        cb_rd;
    logic        pick_ok;
    logic [IW-1:0] pick;
    logic [31:0] head_nx;
    logic [31:0] fill_now;
    logic        full_app;
    logic        ivl_wr;

    // Fill level of the ring for a head and tail
    function automatic logic [31:0] fill_of(input logic [31:0] h, input logic [31:0] t,
                                            input logic [31:0] sz);
        fill_of = (h >= t) ? h - t : h + sz - t;
    endfunction

    // Context qualifiers; the task-switched flag is not an input at all
    assign access_ok = prof_enabled && (cpl == `PRF_RING_USER)
                       && !smm_active && !hyp_active;
    assign count_ok  = access_ok && ev_valid;
    assign xr_clear  = xr_go && xr_feature_en[`PRF_XBIT] && xr_req_mask[`PRF_XBIT]
                       && !xr_presence[`PRF_XBIT];
    assign xr_load   = xr_go && xr_feature_en[`PRF_XBIT] && xr_req_mask[`PRF_XBIT]
                       && xr_presence[`PRF_XBIT];
    assign cb_wr     = reg_wr && (reg_addr == `PRF_RA_CBADDR);
    assign cb_rd     = reg_rd && (reg_addr == `PRF_RA_CBADDR);

    // Ring arithmetic
    assign head_nx  = (head + `PRF_REC_BYTES >= buf_size) ? 32'h0000_0000
                      : head + `PRF_REC_BYTES;
    assign fill_now = fill_of(head, tail, buf_size);
    assign full_app = (fill_now + `PRF_REC_BYTES >= buf_size);
    assign ivl_wr   = (state == PRF_FETCH) && mem_ack && !mem_fault
                      && (idx >= `PRF_FETCH_IVL);

    // Lowest pending counter wins when several overflow together
    always_comb begin
        pick    = '0;
        pick_ok = 1'b0;
        for (int i = NEV - 1; i >= 0; i--) begin
            if (pend[i]) begin
                pick    = IW'(i);
                pick_ok = 1'b1;
            end
        end
    end

    // Cached reload intervals
    prf_mem #(
        .W  (CW),
        .D  (NEV),
        .AW (IW)
    ) u_ivl (
        .core_clk (core_clk),
        .ce       (ce),
        .wr_en    (ivl_wr),
        .wr_addr  (IW'(idx - `PRF_FETCH_IVL)),
        .wr_data  (mem_rdata[CW-1:0]),
        .rd_addr  (pick),
        .rd_data  (ivl_rd)
    );

    // Per-event counters and pending flags, held internally
    generate
        for (genvar g = 0; g < NEV; g++) begin : g_cnt
            always_ff @(posedge core_clk) begin
                if (!resetn || (ce && (xr_clear || xr_load || (cb_wr && reg_wdata == 32'h0)))) begin
                    cnt[g]  <= '0;
                    pend[g] <= 1'b0;
                end else if (ce) begin
                    if (ivl_wr && idx == 4'(g + `PRF_FETCH_IVL)) begin
                        cnt[g] <= mem_rdata[CW-1:0];
                    end else if (reload_p && svc == IW'(g)) begin
                        cnt[g] <= ivl_rd;
                    end else if (count_ok && ev_hit[g] && cfg[`PRF_CFG_EN_LO + g]
                                 && cnt[g] != '0) begin
                        cnt[g] <= cnt[g] - CW'(1);
                    end
                    pend[g] <= (pend[g] && !pend_clr[g]) || (count_ok && ev_hit[g]
                               && cfg[`PRF_CFG_EN_LO + g] && cnt[g] == CW'(1));
                end
            end
        end
    endgenerate

    // Configuration register and its vector output
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            cfg        <= `PRF_CFG_RST;
            thr_vector <= 8'h00;
        end else if (ce) begin
            if (reg_wr && reg_addr == `PRF_RA_CFG) begin
                cfg <= reg_wdata;
            end
            thr_vector <= cfg[`PRF_CFG_VEC_LO +: 8];
        end
    end

    // Register read data, one cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            reg_rdata <= 32'h0000_0000;
        end else if (ce) begin
            reg_rdata <= 32'h0000_0000;
            if (reg_rd) begin
                case (reg_addr)
                    `PRF_RA_CBADDR: reg_rdata <= cb_addr;
                    `PRF_RA_CFG:    reg_rdata <= cfg;
                    `PRF_RA_STAT:   reg_rdata <= {26'h0, state, flush_req, refresh_pend,
                                                  prof_enabled};
                    `PRF_RA_HEAD:   reg_rdata <= head;
                    `PRF_RA_TAIL:   reg_rdata <= tail;
                    default:        reg_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Service pulse for counter reload, in the same cycle as the interval read data
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            reload_p <= 1'b0;
            pend_clr <= '0;
        end else if (ce) begin
            pend_clr <= '0;
            reload_p <= 1'b0;
            if (state == PRF_IDLE && access_ok && !refresh_pend && !flush_req
                && pick_ok && !xr_go && !cb_wr) begin
                pend_clr[pick] <= 1'b1;
                reload_p       <= 1'b1;
            end
        end
    end

    // Memory sequencer, cached control block state and pointers
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state        <= PRF_IDLE;
            cb_addr      <= 32'h0000_0000;
            prof_enabled <= 1'b0;
            buf_base     <= 32'h0000_0000;
            buf_size     <= 32'h0000_0000;
            thr          <= 32'h0000_0000;
            head         <= 32'h0000_0000;
            tail         <= 32'h0000_0000;
            refresh_pend <= 1'b0;
            flush_req    <= 1'b0;
            post_rec     <= 1'b0;
            irq_arm      <= 1'b0;
            idx          <= 4'h0;
            svc          <= '0;
            mem_req      <= 1'b0;
            mem_we       <= 1'b0;
            mem_addr     <= 32'h0000_0000;
            mem_wdata    <= 32'h0000_0000;
            pf_evt       <= 1'b0;
            thr_irq      <= 1'b0;
        end else if (ce) begin
            pf_evt  <= 1'b0;
            thr_irq <= 1'b0;
            if (xr_clear) begin
                cb_addr      <= 32'h0000_0000;
                prof_enabled <= 1'b0;
                buf_base     <= 32'h0000_0000;
                buf_size     <= 32'h0000_0000;
                thr          <= 32'h0000_0000;
                head         <= 32'h0000_0000;
                tail         <= 32'h0000_0000;
                refresh_pend <= 1'b0;
                flush_req    <= 1'b0;
                irq_arm      <= 1'b0;
                mem_req      <= 1'b0;
                state        <= PRF_IDLE;
            end else if (xr_load) begin
                cb_addr      <= xr_cb_addr;
                head         <= xr_head;
                prof_enabled <= (xr_cb_addr != 32'h0);
                refresh_pend <= (xr_cb_addr != 32'h0);
                flush_req    <= 1'b0;
                irq_arm      <= 1'b0;
                mem_req      <= 1'b0;
                state        <= PRF_IDLE;
            end else if (cb_wr) begin
                cb_addr      <= reg_wdata;
                prof_enabled <= (reg_wdata != 32'h0);
                refresh_pend <= (reg_wdata != 32'h0);
                head         <= 32'h0000_0000;
                flush_req    <= 1'b0;
                irq_arm      <= 1'b0;
                mem_req      <= 1'b0;
                state        <= PRF_IDLE;
            end else if (mem_req && mem_ack && mem_fault) begin
                pf_evt  <= 1'b1;
                mem_req <= 1'b0;
                irq_arm <= 1'b0;
                state   <= PRF_IDLE;
            end else begin
                if (cb_rd && prof_enabled) begin
                    flush_req <= 1'b1;
                end
                case (state)
                    PRF_IDLE: begin
                        if (access_ok && refresh_pend) begin
                            state    <= PRF_FETCH;
                            idx      <= 4'h0;
                            mem_req  <= 1'b1;
                            mem_we   <= 1'b0;
                            mem_addr <= cb_addr + `PRF_CB_BASE;
                        end else if (access_ok && flush_req) begin
                            state     <= PRF_HEAD;
                            mem_req   <= 1'b1;
                            mem_we    <= 1'b1;
                            mem_addr  <= cb_addr + `PRF_CB_HEAD;
                            mem_wdata <= head;
                        end else if (access_ok && pick_ok) begin
                            svc <= pick;
                            if (full_app) begin
                                state    <= PRF_TAIL;
                                post_rec <= 1'b0;
                                mem_req  <= 1'b1;
                                mem_we   <= 1'b0;
                                mem_addr <= cb_addr + `PRF_CB_TAIL;
                            end else begin
                                state     <= PRF_REC;
                                mem_req   <= 1'b1;
                                mem_we    <= 1'b1;
                                mem_addr  <= buf_base + head;
                                mem_wdata <= {8'(pick + IW'(1)), ev_ip[23:0]};
                            end
                        end
                    end
                    PRF_FETCH: begin
                        if (mem_ack) begin
                            case (idx)
                                4'h0:    buf_base <= mem_rdata;
                                4'h1:    buf_size <= mem_rdata;
                                4'h2:    thr      <= mem_rdata;
                                4'h3:    tail     <= mem_rdata;
                                default: ;
                            endcase
                            if (idx == FETCH_LAST) begin
                                mem_req      <= 1'b0;
                                refresh_pend <= 1'b0;
                                state        <= PRF_IDLE;
                            end else begin
                                idx      <= idx + 4'h1;
                                mem_addr <= cb_addr + {26'h0, idx + 4'h1, 2'b00};
                            end
                        end
                    end
                    PRF_REC: begin
                        if (mem_ack) begin
                            head <= head_nx;
                            if (fill_of(head_nx, tail, buf_size) >= thr) begin
                                state    <= PRF_TAIL;
                                post_rec <= 1'b1;
                                mem_we   <= 1'b0;
                                mem_addr <= cb_addr + `PRF_CB_TAIL;
                            end else begin
                                mem_req <= 1'b0;
                                state   <= PRF_IDLE;
                            end
                        end
                    end
                    PRF_TAIL: begin
                        if (mem_ack) begin
                            tail <= mem_rdata;
                            if (post_rec) begin
                                if (fill_of(head, mem_rdata, buf_size) >= thr) begin
                                    state     <= PRF_HEAD;
                                    irq_arm   <= 1'b1;
                                    mem_we    <= 1'b1;
                                    mem_addr  <= cb_addr + `PRF_CB_HEAD;
                                    mem_wdata <= head;
                                end else begin
                                    mem_req <= 1'b0;
                                    state   <= PRF_IDLE;
                                end
                            end else if (fill_of(head, mem_rdata, buf_size)
                                         + `PRF_REC_BYTES >= buf_size) begin
                                state    <= PRF_MISSR;
                                mem_addr <= cb_addr + `PRF_CB_MISS;
                            end else begin
                                state     <= PRF_REC;
                                mem_we    <= 1'b1;
                                mem_addr  <= buf_base + head;
                                mem_wdata <= {8'(svc + IW'(1)), ev_ip[23:0]};
                            end
                        end
                    end
                    PRF_HEAD: begin
                        if (mem_ack) begin
                            mem_req   <= 1'b0;
                            flush_req <= 1'b0;
                            thr_irq   <= irq_arm;
                            irq_arm   <= 1'b0;
                            state     <= PRF_IDLE;
                        end
                    end
                    PRF_MISSR: begin
                        if (mem_ack) begin
                            state     <= PRF_MISSW;
                            mem_we    <= 1'b1;
                            mem_wdata <= mem_rdata + 32'h0000_0001;
                        end
                    end
                    PRF_MISSW: begin
                        if (mem_ack) begin
                            mem_req <= 1'b0;
                            state   <= PRF_IDLE;
                        end
                    end
                    default: begin
                        mem_req <= 1'b0;
                        state   <= PRF_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

/* File: sim/prf_core_sva.sv */
`timescale 1ns/1ns
module prf_core_sva (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        resetn,
    // Watched ports
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [1:0]  cpl,
    input wire logic        smm_active,
    input wire logic        hyp_active,
    input wire logic        xr_go,
    input wire logic [63:0] xr_feature_en,
    input wire logic [63:0] xr_req_mask,
    input wire logic [63:0] xr_presence,
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic        mem_ack,
    input wire logic        mem_fault,
    input wire logic        pf_evt,
    input wire logic        thr_irq,
    input wire logic        prof_enabled
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    // Memory traffic only from user context
    user_ring_a: assert property ($rose(mem_req) |-> cpl == 2'h3 && !smm_active && !hyp_active)
        else $error("memory access outside user context");
    disabled_quiet_a: assert property (!prof_enabled |-> !$rose(mem_req))
        else $error("memory access while disabled");
    // Request held until answered
    req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
        && $stable(mem_we) && $stable(mem_wdata))
        else $error("request changed before answer");
    // Page fault pulse
    fault_pulse_a: assert property (mem_req && mem_ack && mem_fault |=> pf_evt ##1 !pf_evt)
        else $error("page fault not signalled");
    // Interrupt only after the head write lands
    irq_cause_a: assert property (thr_irq |-> $past(mem_ack && mem_we) && !$past(thr_irq))
        else $error("threshold interrupt without head write");
    restore_off_a: assert property (xr_go && xr_feature_en[62] && xr_req_mask[62]
        && !xr_presence[62] |-> ##[1:2] !prof_enabled)
        else $error("empty restore left profiling on");
    restore_noirq_a: assert property (xr_go |=> !thr_irq [*2])
        else $error("restore raised interrupt");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside answer cycle");

    // Main scenarios
    cover property (thr_irq);
    cover property (pf_evt);
    cover property (mem_ack && !mem_we);
endmodule

bind prf_core prf_core_sva u_sva (.*);

/* File: sim/prf_umem.sv */
`timescale 1ns/1ns
module prf_umem (
    // Clock
    input  wire logic        core_clk,
    // Memory port
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_addr,
    input  wire logic [31:0] mem_wdata,
    output logic             mem_ack,
    output logic             mem_fault,
    output logic      [31:0] mem_rdata,
    // Bench controls
    input  wire logic [3:0]  lat,
    input  wire logic        absent
);
    logic [31:0] m [0:127];
    logic [3:0]  wt = 4'h0;

    initial mem_ack = 1'b0;
    initial mem_fault = 1'b0;
    initial mem_rdata = 32'h5A5A_A5A5;

    // Answer after lat idle cycles; data lines toggle when released
    always @(posedge core_clk) begin
        mem_ack <= 1'b0;
        mem_fault <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_req && !mem_ack) begin
            wt <= wt + 4'h1;
            if (wt >= lat) begin
                wt <= 4'h0;
                mem_ack <= 1'b1;
                mem_fault <= absent;
                if (!mem_we)
                    mem_rdata <= m[mem_addr[8:2]];
                else if (!absent)
                    m[mem_addr[8:2]] <= mem_wdata;
            end
        end
    end
endmodule

/* File: sim/tb_profiling_event_ring_state.sv */
`timescale 1ns/1ns
module tb_profiling_event_ring_state;
    localparam logic [31:0] CB = 32'h0000_0080;
    localparam logic [63:0] XB = 64'h4000_0000_0000_0000;
    logic        core_clk, resetn, reg_wr, reg_rd, ev_valid, xr_go, pres, absent;
    logic        smm_active, hyp_active;
    logic        mem_req, mem_we, mem_ack, mem_fault, pf_evt, thr_irq, prof_enabled;
    logic [7:0]  reg_addr, thr_vector;
    logic [31:0] reg_wdata, reg_rdata, ev_ip, xa, xh, mem_addr, mem_wdata, mem_rdata;
    logic [5:0]  ev_hit;
    logic [1:0]  cpl;
    logic [3:0]  lat;
    int          err_count, check_count, irq_n, pf_n;

    prf_core dut (.ce(1'b1), .xr_feature_en(XB),
        .xr_req_mask(XB), .xr_presence(pres ? XB : 64'h0), .xr_cb_addr(xa), .xr_head(xh), .*);
    prf_umem um (.*);

    // Clock
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // Pulse counters
    always @(posedge core_clk) begin
        irq_n <= irq_n + int'(thr_irq);
        pf_n <= pf_n + int'(pf_evt);
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
        @(posedge core_clk);
    endtask
    // Wait until the memory port stays quiet
    task automatic settle();
        int q;
        q = 0;
        for (int i = 0; i < 400 && q < 6; i++) begin
            @(posedge core_clk);
            q = mem_req ? 0 : q + 1;
        end
    endtask
    task automatic fire(input logic [31:0] ip);
        @(posedge core_clk);
        ev_valid <= 1'b1;
        ev_hit <= 6'h03;
        ev_ip <= ip;
        @(posedge core_clk);
        ev_valid <= 1'b0;
        settle();
    endtask
    task automatic restore(input logic p);
        @(posedge core_clk);
        pres <= p;
        xr_go <= 1'b1;
        @(posedge core_clk);
        xr_go <= 1'b0;
        settle();
    endtask

    // Load in kernel, then fetch in user ring
    task automatic t_load();
        um.m[32] = 32'h0000_0100;
        um.m[33] = 32'h0000_0010;
        um.m[34] = 32'h0000_0008;
        um.m[35] = 32'h0000_0000;
        for (int i = 36; i < 42; i++) um.m[i] = 32'h0000_0001;
        chk(prof_enabled, 0);
        rd(8'h14, 0);
        wr(8'h04, 32'h0000_015A);
        wr(8'h00, CB);
        repeat (8) @(posedge core_clk);
        chk(mem_req, 0);
        rd(8'h04, 32'h0000_015A);
        chk(thr_vector, 32'h5A);
        cpl <= 2'h3;
        settle();
        chk(prof_enabled, 1);
    endtask
    // Two records reach the threshold
    task automatic t_thresh();
        fire(32'hAB12_3456);
        chk(um.m[64], 32'h0112_3456);
        chk(irq_n, 0);
        fire(32'h0000_0002);
        chk(um.m[65], 32'h0100_0002);
        chk(um.m[48], 32'h0000_0008);
        chk(irq_n, 1);
        rd(8'h0C, 32'h0000_0008);
    endtask
    // Software drained; reread tail cancels interrupt
    task automatic t_drain();
        um.m[35] = 32'h0000_0008;
        lat <= 4'h3;
        fire(32'h0000_0003);
        chk(um.m[66], 32'h0100_0003);
        rd(8'h10, 32'h0000_0008);
        chk(irq_n, 1);
    endtask
    task automatic t_fault();
        absent <= 1'b1;
        fire(32'h0000_0004);
        chk(pf_n, 1);
        absent <= 1'b0;
        rd(8'h0C, 32'h0000_000C);
    endtask
    task automatic t_restore();
        cpl <= 2'h0;
        xa <= CB;
        xh <= 32'h0000_000C;
        restore(1'b1);
        chk(irq_n, 1);
        rd(8'h0C, 32'h0000_000C);
        wr(8'h04, 32'h0000_015A);
        restore(1'b0);
        chk(prof_enabled, 0);
        rd(8'h00, 0);
    endtask
    // Restart under hypervisor, then fill the ring until a record is missed
    task automatic t_full();
        um.m[34] = 32'h0000_0010;
        um.m[35] = 32'h0000_0000;
        um.m[49] = 32'h0000_0000;
        hyp_active <= 1'b1;
        cpl <= 2'h3;
        wr(8'h00, CB);
        repeat (4) @(posedge core_clk);
        chk(mem_req, 0);
        hyp_active <= 1'b0;
        settle();
        for (int i = 0; i < 4; i++) fire(i);
        chk(um.m[49], 32'h0000_0001);
        rd(8'h0C, 32'h0000_000C);
    endtask

    task automatic give_verdict();
        if (err_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Main sequence
    initial begin
        {reg_wr, reg_rd, ev_valid, xr_go, pres, absent, smm_active, hyp_active} = 8'h00;
        {reg_addr, reg_wdata, ev_ip, xa, xh, ev_hit, cpl, lat} = '0;
        {err_count, check_count, irq_n, pf_n} = '0;
        resetn = 1'b0;
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        t_load();
        t_thresh();
        t_drain();
        t_fault();
        t_restore();
        t_full();
        give_verdict();
    end

    // Watchdog
    initial begin
        repeat (5000) @(posedge core_clk);
        err_count++;
        give_verdict();
    end
endmodule
